//--- hdl/pd_monitor_status_regs.sv
// powered-device status, spread-spectrum, measurement and margin registers
// assumes analog words are held steady across each conversion toggle edge
//
// Contract
// - aux alarm threshold is an 8-bit linear code, zero is 0 V, ones full scale.
// - local supply bit reads one while a local supply is present.
// - high-power bit reads one for a Type 2 source or local power.
// - current-limit bit reads one for the higher source current limit.
// - modulation enable bit turns PWM clock modulation on or off.
// - modulation type bit: one fractional-n, zero pseudo-random sequence.
// - amount 00 2%, 01 5%, 10 10%; 11 reserved; ignored for pseudo-random.
// - voltage register reports 8-bit linear input voltage, valid in local power.
// - current register holds 5-bit reading, upper three bits reserved, source power only.
// - current scale doubles when the current-limit bit is high.
// - over-current alarm sets when measured current exceeds programmed 5-bit threshold.
// - threshold shares current scaling; alarm comparison invalid in local power.
// - margin 000 none, 001 -5%, 010 -2.5%, 011 +2.5%, 100 +5%; rest reserved.
// - Type 2 detection shows on the pin in hardware mode, register in software.
`timescale 1ns/1ps
`default_nettype none
`include "pd_regs_defs.svh"

module pd_monitor_status_regs
	import pd_regs_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// serial management pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// analog front end
	input  wire analog_in_t  meas_in,
	// controls toward the converter
	output spread_ctrl_t     spread_ctrl,
	output logic [2:0]       margin_sel,
	// status pins
	output logic             high_power_source_detected,
	output logic             overcurrent_alarm,
	output logic             aux_alarm
);

	localparam int MEAS_W = $bits(analog_in_t);

	logic [MEAS_W-1:0] meas_raw, meas_s1_r, meas_s2_r;
	analog_in_t        meas_s;
	reg_req_t          req;
	logic [7:0]        rdata;

	logic [7:0] aux_thr_r, aux_thr_nxt;
	logic [3:0] ctrl_r, ctrl_nxt;
	logic [4:0] oc_thr_r, oc_thr_nxt;
	logic [2:0] margin_r, margin_nxt;

	logic [7:0] volt_r, volt_nxt;
	logic [4:0] cur_r, cur_nxt;
	logic [7:0] aux_r, aux_nxt;
	logic       conv_d_r, conv_d_nxt;
	logic       sw_mode_r, sw_mode_nxt;
	logic [1:0] settle_r, settle_nxt;

	logic       oc_alarm_r, oc_alarm_nxt;
	logic       aux_alarm_r, aux_alarm_nxt;
	logic       hp_pin_r, hp_pin_nxt;
	logic       conv_edge, hp_status;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	serial_mgmt_slave u_slave (
		.clk     (clk),
		.rst     (rst),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.sda_out (sda_out),
		.sda_oe  (sda_oe),
		.req     (req),
		.rdata   (rdata)
	);

	// every analog-side bit crosses on its own pair of flops
	assign meas_raw = meas_in;
	genvar gi;
	generate
		for (gi = 0; gi < MEAS_W; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					meas_s1_r[gi] <= 1'b0;
					meas_s2_r[gi] <= 1'b0;
				end else begin
					meas_s1_r[gi] <= meas_raw[gi];
					meas_s2_r[gi] <= meas_s1_r[gi];
				end
			end
		end
	endgenerate
	assign meas_s = analog_in_t'(meas_s2_r);

	// software-written controls
	always_comb begin
		aux_thr_nxt = aux_thr_r;
		ctrl_nxt    = ctrl_r;
		oc_thr_nxt  = oc_thr_r;
		margin_nxt  = margin_r;
		if (req.wr) begin
			if (hit(req.addr, `OFF_AUX_THR)) begin
				aux_thr_nxt = req.wdata;
			end
			if (hit(req.addr, `OFF_CTRL)) begin
				ctrl_nxt[`BIT_MOD_EN]   = req.wdata[`BIT_MOD_EN];
				ctrl_nxt[`BIT_MOD_FRAC] = req.wdata[`BIT_MOD_FRAC];
				// a reserved amount keeps the last legal one
				if (req.wdata[1:0] != `AMT_RSVD) begin
					ctrl_nxt[1:0] = req.wdata[1:0];
				end
			end
			if (hit(req.addr, `OFF_OC_THR)) begin
				oc_thr_nxt = req.wdata[4:0];
			end
			if (hit(req.addr, `OFF_MARGIN) && req.wdata[2:0] <= `MARGIN_MAX) begin
				margin_nxt = req.wdata[2:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aux_thr_r <= `RST_AUX_THR;
			ctrl_r    <= `RST_CTRL;
			oc_thr_r  <= `RST_OC_THR;
			margin_r  <= `RST_MARGIN;
		end else begin
			aux_thr_r <= aux_thr_nxt;
			ctrl_r    <= ctrl_nxt;
			oc_thr_r  <= oc_thr_nxt;
			margin_r  <= margin_nxt;
		end
	end

	// conversion capture; bus writes never reach these
	// no false edge while the synchroniser refills after reset
	assign conv_edge = (meas_s.conversion_toggle ^ conv_d_r) & (settle_r == 2'h3);

	always_comb begin
		volt_nxt       = volt_r;
		cur_nxt        = cur_r;
		aux_nxt        = aux_r;
		conv_d_nxt     = meas_s.conversion_toggle;
		sw_mode_nxt    = sw_mode_r;
		settle_nxt     = settle_r;
		if (conv_edge) begin
			volt_nxt = meas_s.input_voltage_code;
			cur_nxt  = meas_s.input_current_code;
			aux_nxt  = meas_s.aux_analog_input_code;
		end
		if (settle_r != 2'h3) begin
			settle_nxt = settle_r + 2'h1;
		end
		// strap is caught once, on the third edge after release, when the flops hold real pin levels
		if (settle_r == 2'h2) begin
			sw_mode_nxt = meas_s.software_mode_strap;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			volt_r       <= `RST_READING;
			cur_r        <= 5'h00;
			aux_r        <= `RST_READING;
			conv_d_r     <= 1'b0;
			sw_mode_r    <= 1'b0;
			settle_r     <= 2'h0;
		end else begin
			volt_r       <= volt_nxt;
			cur_r        <= cur_nxt;
			aux_r        <= aux_nxt;
			conv_d_r     <= conv_d_nxt;
			sw_mode_r    <= sw_mode_nxt;
			settle_r     <= settle_nxt;
		end
	end

	// status and alarms
	assign hp_status = meas_s.high_power_source_detected | meas_s.local_supply_detected;

	always_comb begin
		// the current reading means nothing on local power, so neither does the alarm
		oc_alarm_nxt  = (cur_r > oc_thr_r) & ~meas_s.local_supply_detected;
		aux_alarm_nxt = aux_r > aux_thr_r;
		// pin stays low until the strap is known, so software mode never sees a pulse
		hp_pin_nxt    = hp_status & ~sw_mode_r & (settle_r == 2'h3);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			oc_alarm_r  <= 1'b0;
			aux_alarm_r <= 1'b0;
			hp_pin_r    <= 1'b0;
		end else begin
			oc_alarm_r  <= oc_alarm_nxt;
			aux_alarm_r <= aux_alarm_nxt;
			hp_pin_r    <= hp_pin_nxt;
		end
	end

	// read mux; unmapped and reserved locations read zero
	always_comb begin
		rdata = 8'h00;
		case (req.addr)
			`OFF_AUX_THR: rdata = aux_thr_r;
			`OFF_CTRL: begin
				rdata[`BIT_LOCAL] = meas_s.local_supply_detected;
				rdata[`BIT_HP]    = hp_status & sw_mode_r;
				rdata[`BIT_CURRENT_LIMIT_SELECT]  = meas_s.current_limit_select;
				rdata[3:0]        = ctrl_r;
			end
			`OFF_VOLT:   rdata = volt_r;
			`OFF_CUR:    rdata = {3'h0, cur_r};
			`OFF_OC_THR: rdata = {3'h0, oc_thr_r};
			`OFF_MARGIN: rdata = {5'h00, margin_r};
			`OFF_RSVD:   rdata = 8'h00;
			default:     rdata = 8'h00;
		endcase
	end

	// pseudo-random modulation takes no amount
	assign spread_ctrl.enable     = ctrl_r[`BIT_MOD_EN];
	assign spread_ctrl.fractional = ctrl_r[`BIT_MOD_FRAC];
	assign spread_ctrl.amount     = ctrl_r[`BIT_MOD_FRAC] ? ctrl_r[1:0] : 2'h0;
	assign margin_sel                 = margin_r;
	assign high_power_source_detected = hp_pin_r;
	assign overcurrent_alarm          = oc_alarm_r;
	assign aux_alarm                  = aux_alarm_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ctrl_write;
		req.wr && hit(req.addr, `OFF_CTRL);
	endsequence

	sequence s_margin_write;
		req.wr && hit(req.addr, `OFF_MARGIN);
	endsequence

	property p_aux_alarm;
		(aux_r > aux_thr_r) |=> aux_alarm;
	endproperty
	a_aux_alarm: assert property (p_aux_alarm) else $error("aux alarm missed");

	property p_local_bit;
		##3 hit(req.addr, `OFF_CTRL) |->
			rdata[`BIT_LOCAL] == $past(meas_in.local_supply_detected, 2);
	endproperty
	a_local_bit: assert property (p_local_bit) else $error("local bit wrong");

	property p_hp_bit;
		##3 (hit(req.addr, `OFF_CTRL) && sw_mode_r) |-> rdata[`BIT_HP] ==
			($past(meas_in.high_power_source_detected, 2) | $past(meas_in.local_supply_detected, 2));
	endproperty
	a_hp_bit: assert property (p_hp_bit) else $error("high-power bit wrong");

	property p_current_limit_select_bit;
		##3 hit(req.addr, `OFF_CTRL) |->
			rdata[`BIT_CURRENT_LIMIT_SELECT] == $past(meas_in.current_limit_select, 2);
	endproperty
	a_current_limit_select_bit: assert property (p_current_limit_select_bit) else $error("limit bit wrong");

	property p_mod_ctrl;
		s_ctrl_write |=> (spread_ctrl.enable == $past(req.wdata[3])) &&
			(spread_ctrl.fractional == $past(req.wdata[2]));
	endproperty
	a_mod_ctrl: assert property (p_mod_ctrl) else $error("modulation control not taken");

	property p_amount_rsvd;
		s_ctrl_write ##0 (req.wdata[1:0] == 2'h3) |=> $stable(ctrl_r[1:0]);
	endproperty
	a_amount_rsvd: assert property (p_amount_rsvd) else $error("reserved amount taken");

	property p_volt_capture;
		conv_edge |=> volt_r == $past(meas_s.input_voltage_code) ##1 $stable(volt_r) || conv_edge;
	endproperty
	a_volt_capture: assert property (p_volt_capture) else $error("voltage not captured");

	property p_cur_upper;
		hit(req.addr, `OFF_CUR) |-> rdata[7:5] == 3'h0;
	endproperty
	a_cur_upper: assert property (p_cur_upper) else $error("current upper bits set");

	property p_oc_alarm;
		((cur_r > oc_thr_r) && !meas_s.local_supply_detected) |=> overcurrent_alarm;
	endproperty
	a_oc_alarm: assert property (p_oc_alarm) else $error("over-current alarm missed");

	property p_oc_local;
		meas_s.local_supply_detected |=> !overcurrent_alarm;
	endproperty
	a_oc_local: assert property (p_oc_local) else $error("alarm raised on local power");

	property p_margin_rsvd;
		s_margin_write ##0 (req.wdata[2:0] > 3'h4) |=> $stable(margin_sel);
	endproperty
	a_margin_rsvd: assert property (p_margin_rsvd) else $error("reserved margin taken");

	property p_hp_pin;
		(hp_status && !sw_mode_r && settle_r == 2'h3) |=> high_power_source_detected;
	endproperty
	a_hp_pin: assert property (p_hp_pin) else $error("high-power pin missed");

	property p_ro_write;
		req.wr && hit(req.addr, `OFF_VOLT) && !conv_edge |=> $stable(volt_r);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only register written");

endmodule

`default_nettype wire

//--- hdl/pd_regs_defs.svh
// offsets, field positions and reset values of the powered-device status bank
// assumes inclusion by bare name from the register modules and the bench files
`ifndef PD_REGS_DEFS_SVH
`define PD_REGS_DEFS_SVH

`define OFF_AUX_THR  8'h09
`define OFF_CTRL     8'h0a
`define OFF_VOLT     8'h0b
`define OFF_CUR      8'h0c
`define OFF_OC_THR   8'h0d
`define OFF_MARGIN   8'h0e
`define OFF_RSVD     8'h0f

`define RST_AUX_THR  8'hff
`define RST_CTRL     4'h0
`define RST_OC_THR   5'h1f
`define RST_MARGIN   3'h0
`define RST_READING  8'h00

`define BIT_LOCAL    6
`define BIT_HP       5
`define BIT_CURRENT_LIMIT_SELECT     4
`define BIT_MOD_EN   3
`define BIT_MOD_FRAC 2

`define AMT_RSVD     2'h3
`define MARGIN_MAX   3'h4

// serial management address, arbitrary value
`define DEV_ADDR     7'h2a

`endif

//--- hdl/pd_regs_pkg.sv
// types shared by the status bank and its serial management slave
// assumes the constants header sits beside it
package pd_regs_pkg;

	// outside-domain inputs, all passed through a two-flop synchroniser
	typedef struct packed {
		logic       local_supply_detected;
		logic       high_power_source_detected;
		logic       current_limit_select;
		logic       software_mode_strap;
		logic       conversion_toggle;
		logic [7:0] input_voltage_code;
		logic [4:0] input_current_code;
		logic [7:0] aux_analog_input_code;
	} analog_in_t;

	typedef struct packed {
		logic       enable;
		logic       fractional;
		logic [1:0] amount;
	} spread_ctrl_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_ADDR  = 9'h002,
		ST_ACK_A = 9'h004,
		ST_PTR   = 9'h008,
		ST_ACK_P = 9'h010,
		ST_WRITE = 9'h020,
		ST_ACK_W = 9'h040,
		ST_READ  = 9'h080,
		ST_RACK  = 9'h100
	} slave_state_t;

endpackage

//--- hdl/serial_mgmt_slave.sv
// two-wire serial management slave: address byte, pointer byte, auto-increment
// assumes an open-drain data line resolved outside; scl is a slow pin, oversampled
`timescale 1ns/1ps
`default_nettype none
`include "pd_regs_defs.svh"

module serial_mgmt_slave
	import pd_regs_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// serial pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// register access
	output reg_req_t        req,
	input  wire logic [7:0] rdata
);

	logic         scl_s1_r, scl_s2_r, scl_d_r;
	logic         sda_s1_r, sda_s2_r, sda_d_r;
	slave_state_t state_r, state_nxt;
	logic [2:0]   bitcnt_r, bitcnt_nxt;
	logic [7:0]   shreg_r, shreg_nxt;
	logic [7:0]   ptr_r, ptr_nxt;
	logic         rw_r, rw_nxt;
	logic         got_r, got_nxt;
	logic         oe_r, oe_nxt;
	logic         wr_r, wr_nxt;
	logic         start_ev, stop_ev, rise, fall;

	always_ff @(posedge clk) begin
		if (rst) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
		end
	end

	assign start_ev = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign stop_ev  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	assign rise     = scl_s2_r & ~scl_d_r;
	assign fall     = ~scl_s2_r & scl_d_r;

	always_comb begin
		state_nxt  = state_r;
		bitcnt_nxt = bitcnt_r;
		shreg_nxt  = shreg_r;
		ptr_nxt    = ptr_r;
		rw_nxt     = rw_r;
		got_nxt    = got_r;
		oe_nxt     = oe_r;
		wr_nxt     = 1'b0;
		if (stop_ev) begin
			state_nxt = ST_IDLE;
			oe_nxt    = 1'b0;
		end else if (start_ev) begin
			state_nxt  = ST_ADDR;
			bitcnt_nxt = 3'h0;
			got_nxt    = 1'b0;
			oe_nxt     = 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
				end
				ST_ADDR, ST_PTR, ST_WRITE: begin
					if (rise) begin
						shreg_nxt  = {shreg_r[6:0], sda_s2_r};
						bitcnt_nxt = bitcnt_r + 3'h1;
						got_nxt    = (bitcnt_r == 3'h7);
					end else if (fall && got_r) begin
						got_nxt = 1'b0;
						oe_nxt  = 1'b1;
						if (state_r == ST_ADDR) begin
							// foreign address: stay off the line until the next start
							if (shreg_r[7:1] == `DEV_ADDR) begin
								rw_nxt    = shreg_r[0];
								state_nxt = ST_ACK_A;
							end else begin
								oe_nxt    = 1'b0;
								state_nxt = ST_IDLE;
							end
						end else if (state_r == ST_PTR) begin
							ptr_nxt   = shreg_r;
							state_nxt = ST_ACK_P;
						end else begin
							wr_nxt    = 1'b1;
							state_nxt = ST_ACK_W;
						end
					end
				end
				ST_ACK_A: begin
					if (fall) begin
						bitcnt_nxt = 3'h0;
						if (rw_r) begin
							shreg_nxt = rdata;
							oe_nxt    = ~rdata[7];
							state_nxt = ST_READ;
						end else begin
							oe_nxt    = 1'b0;
							state_nxt = ST_PTR;
						end
					end
				end
				ST_ACK_P, ST_ACK_W: begin
					if (fall) begin
						oe_nxt    = 1'b0;
						state_nxt = ST_WRITE;
						if (state_r == ST_ACK_W) begin
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				ST_READ: begin
					if (rise) begin
						bitcnt_nxt = bitcnt_r + 3'h1;
						got_nxt    = (bitcnt_r == 3'h7);
					end else if (fall) begin
						if (got_r) begin
							got_nxt   = 1'b0;
							oe_nxt    = 1'b0;
							state_nxt = ST_RACK;
						end else begin
							shreg_nxt = {shreg_r[6:0], 1'b0};
							oe_nxt    = ~shreg_r[6];
						end
					end
				end
				ST_RACK: begin
					if (rise) begin
						if (sda_s2_r) begin
							state_nxt = ST_IDLE;
						end else begin
							ptr_nxt = ptr_r + 8'h01;
							got_nxt = 1'b1;
						end
					end else if (fall && got_r) begin
						got_nxt    = 1'b0;
						bitcnt_nxt = 3'h0;
						shreg_nxt  = rdata;
						oe_nxt     = ~rdata[7];
						state_nxt  = ST_READ;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
					oe_nxt    = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r  <= ST_IDLE;
			bitcnt_r <= 3'h0;
			shreg_r  <= 8'h00;
			ptr_r    <= 8'h00;
			rw_r     <= 1'b0;
			got_r    <= 1'b0;
			oe_r     <= 1'b0;
			wr_r     <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			bitcnt_r <= bitcnt_nxt;
			shreg_r  <= shreg_nxt;
			ptr_r    <= ptr_nxt;
			rw_r     <= rw_nxt;
			got_r    <= got_nxt;
			oe_r     <= oe_nxt;
			wr_r     <= wr_nxt;
		end
	end

	assign sda_out   = 1'b0;
	assign sda_oe    = oe_r;
	assign req.wr    = wr_r;
	assign req.addr  = ptr_r;
	assign req.wdata = shreg_r;

endmodule

`default_nettype wire

//--- tb/serial_host.sv
// host model: two-wire management master driving clock and pulling data low
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
`include "pd_regs_defs.svh"

module serial_host (
	// clock
	input  wire logic clk,
	// wire side
	output var logic  scl,
	output var logic  sda_low,
	input  wire logic sda_line
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// phases of 10 clk keep clear of the 8 clk minimum
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// data moves only while scl is low, 4 clk after the fall
	task automatic xfer_bit(input logic b, output logic r);
		sda_low <= ~b;
		tick(10);
		scl <= 1'b1;
		tick(10);
		r = sda_line;
		scl <= 1'b0;
		tick(4);
	endtask

	task automatic xfer_byte(input logic [7:0] d, input logic ab, output logic [7:0] r,
		output logic k);
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], r[i]);
		end
		xfer_bit(ab, k);
	endtask

	task automatic start_cond();
		sda_low <= 1'b1;
		tick(10);
		scl <= 1'b0;
		tick(4);
	endtask

	task automatic restart_cond();
		sda_low <= 1'b0;
		tick(10);
		scl <= 1'b1;
		tick(10);
		start_cond();
	endtask

	task automatic stop_cond();
		sda_low <= 1'b1;
		tick(10);
		scl <= 1'b1;
		tick(10);
		sda_low <= 1'b0;
		tick(10);
	endtask

	// one data byte per write, so auto-increment never spills into reserved places
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k0, k1, k2;
		start_cond();
		xfer_byte({`DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer_byte(a, 1'b1, r, k1);
		xfer_byte(d, 1'b1, r, k2);
		stop_cond();
		ok = !(k0 | k1 | k2);
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k0, k1, k2, k3;
		start_cond();
		xfer_byte({`DEV_ADDR, 1'b0}, 1'b1, r, k0);
		xfer_byte(a, 1'b1, r, k1);
		restart_cond();
		xfer_byte({`DEV_ADDR, 1'b1}, 1'b1, r, k2);
		xfer_byte(8'hff, 1'b1, d, k3);
		stop_cond();
		ok = !(k0 | k1 | k2);
	endtask

	task automatic probe(input logic [6:0] dev, output logic ack);
		logic [7:0] r;
		logic       k;
		start_cond();
		xfer_byte({dev, 1'b0}, 1'b1, r, k);
		stop_cond();
		ack = !k;
	endtask
endmodule
`default_nettype wire

//--- tb/test_pd_monitor_status_regs.sv
// bench for the status bank: register traffic through the host model
// assumes one 250 MHz clock and a pulled-up data line
`timescale 1ns/1ps
`default_nettype none
`include "pd_regs_defs.svh"

module test_pd_monitor_status_regs;
	import pd_regs_pkg::*;

	logic         clk;
	logic         rst;
	analog_in_t   meas_in;
	logic         scl;
	logic         sda_low;
	logic         sda_line;
	logic         sda_out;
	logic         sda_oe;
	spread_ctrl_t spread_ctrl;
	logic [2:0]   margin_sel;
	logic         hp_pin;
	logic         oc_alarm;
	logic         aux_alarm;
	logic         ok;
	int           fails;
	int           n_compared;
	logic [7:0]   rst_addr [8] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
	logic [7:0]   rst_val  [8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00};

	// either party pulling low wins over the pull-up
	assign sda_line = ~(sda_low | sda_oe);

	pd_monitor_status_regs u_dut (
		.clk                        (clk),
		.rst                        (rst),
		.scl_in                     (scl),
		.sda_in                     (sda_line),
		.sda_out                    (sda_out),
		.sda_oe                     (sda_oe),
		.meas_in                    (meas_in),
		.spread_ctrl                (spread_ctrl),
		.margin_sel                 (margin_sel),
		.high_power_source_detected (hp_pin),
		.overcurrent_alarm          (oc_alarm),
		.aux_alarm                  (aux_alarm)
	);

	serial_host u_host (
		.clk      (clk),
		.scl      (scl),
		.sda_low  (sda_low),
		.sda_line (sda_line)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.write_reg(a, d, ok);
		check("write ack", 8'h01, {7'h0, ok});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		logic [7:0] d;
		u_host.read_reg(a, d, ok);
		check("read ack", 8'h01, {7'h0, ok});
		check($sformatf("reg %h", a), exp & m, d & m);
	endtask

	// codes settle first, then the toggle marks a new conversion
	task automatic convert(input logic [7:0] v, input logic [4:0] c, input logic [7:0] x);
		meas_in.input_voltage_code <= v;
		meas_in.input_current_code <= c;
		meas_in.aux_analog_input_code <= x;
		wait_clk(4);
		meas_in.conversion_toggle <= ~meas_in.conversion_toggle;
		wait_clk(8);
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		wait_clk(90000);
		fails++;
		$display("MISMATCH run length expected done seen hung");
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		meas_in = '0;
		meas_in.software_mode_strap = 1'b1;
		fails = 0;
		n_compared = 0;
		wait_clk(8);
		rst <= 1'b0;
		wait_clk(6);
		for (int i = 0; i < 8; i++) begin
			rd_chk(rst_addr[i], rst_val[i], 8'hff);
		end
		check("sda out", 8'h00, {7'h0, sda_out});
		u_host.probe(7'h2b, ok);
		check("foreign address ack", 8'h00, {7'h0, ok});
		for (int i = 0; i < 3; i++) begin
			wr(`OFF_CTRL, 8'h0c | 8'(i));
			check("spread", {6'h03, 2'(i)}, {4'h0, spread_ctrl});
		end
		wr(`OFF_CTRL, 8'h0f);
		check("spread", 8'h0e, {4'h0, spread_ctrl});
		rd_chk(`OFF_CTRL, 8'h0e, 8'h0f);
		wr(`OFF_CTRL, 8'h0a);
		check("spread", 8'h08, {4'h0, spread_ctrl});
		wr(`OFF_CTRL, 8'h00);
		check("spread", 8'h00, {4'h0, spread_ctrl});
		for (int i = 0; i < 5; i++) begin
			wr(`OFF_MARGIN, 8'(i));
			check("margin", 8'(i), {5'h0, margin_sel});
		end
		wr(`OFF_MARGIN, 8'h05);
		rd_chk(`OFF_MARGIN, 8'h04, 8'hff);
		convert(8'ha5, 5'h13, 8'h80);
		rd_chk(`OFF_VOLT, 8'ha5, 8'hff);
		rd_chk(`OFF_CUR, 8'h13, 8'hff);
		u_host.write_reg(`OFF_VOLT, 8'h00, ok);
		rd_chk(`OFF_VOLT, 8'ha5, 8'hff);
		check("aux alarm", 8'h00, {7'h0, aux_alarm});
		wr(`OFF_AUX_THR, 8'h7f);
		check("aux alarm", 8'h01, {7'h0, aux_alarm});
		wr(`OFF_OC_THR, 8'h13);
		check("oc alarm", 8'h00, {7'h0, oc_alarm});
		rd_chk(`OFF_OC_THR, 8'h13, 8'hff);
		wr(`OFF_OC_THR, 8'h12);
		check("oc alarm", 8'h01, {7'h0, oc_alarm});
		meas_in.high_power_source_detected <= 1'b1;
		meas_in.current_limit_select <= 1'b1;
		wait_clk(8);
		rd_chk(`OFF_CTRL, 8'h30, 8'hf0);
		check("hp pin", 8'h00, {7'h0, hp_pin});
		meas_in.current_limit_select <= 1'b0;
		meas_in.high_power_source_detected <= 1'b0;
		meas_in.local_supply_detected <= 1'b1;
		wait_clk(8);
		check("oc alarm", 8'h00, {7'h0, oc_alarm});
		// current-limit bit is left out of the compare mask while local supply is present
		rd_chk(`OFF_CTRL, 8'h60, 8'he0);
		meas_in.local_supply_detected <= 1'b0;
		wait_clk(8);
		rd_chk(`OFF_CTRL, 8'h00, 8'hf0);
		rst <= 1'b1;
		meas_in.software_mode_strap <= 1'b0;
		meas_in.high_power_source_detected <= 1'b1;
		wait_clk(8);
		rst <= 1'b0;
		wait_clk(6);
		check("margin", 8'h00, {5'h0, margin_sel});
		check("hp pin", 8'h01, {7'h0, hp_pin});
		rd_chk(`OFF_CTRL, 8'h00, 8'h20);
		wrap_up();
	end
endmodule
`default_nettype wire
